// *** rtl/ebus_seq.sv ***
// Non-multiplexed external bus cycle sequencer
module ebus_seq
    import ebus_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    // Configuration
    input  wire logic                pci_fast_i,
    input  wire logic [1:0]          mode_i,
    input  wire logic [WS_W-1:0]     wait_state_count_i,
    input  wire logic [DC_W-1:0]     dead_cycle_count_i,
    // Request
    input  wire logic                req_i,
    input  wire logic [CS_IDX_W-1:0] req_cs_i,
    input  wire logic                req_read_i,
    input  wire logic [ADDR_W-1:0]   req_addr_i,
    input  wire logic [DATA_W-1:0]   req_wdata_i,
    input  wire logic [TSIZE_W-1:0]  req_size_i,
    // Answer
    output logic                     accept_o,
    output logic                     done_o,
    output logic                     busy_o,
    output logic                     acked_o,
    output logic [DATA_W-1:0]        rdata_o,
    // Bus pins
    output logic                     pci_clk_o,
    output logic [CS_COUNT-1:0]      cs_n_o,
    output logic [ADDR_W-1:0]        addr_o,
    output logic                     addr_hi_oe_o,
    output logic                     rw_o,
    output logic                     oe_n_o,
    output logic [DATA_W-1:0]        data_o,
    output logic                     data_oe_o,
    input  wire logic [DATA_W-1:0]   data_i,
    input  wire logic                ack_n_i,
    output logic                     transfer_start_strobe_n_o,
    output logic [TSIZE_W-1:0]       transfer_size_field_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_STROBE,
        ST_TRAIL,
        ST_DEAD
    } seq_state_t;

    seq_state_t           state;
    logic [CNT_W-1:0]     cnt;
    logic                 addr_pend;
    logic [CS_IDX_W-1:0]  cs_idx;
    logic [ADDR_W-1:0]    addr_q;
    logic [1:0]           mode_q;
    logic [WS_W-1:0]      wait_state_count;
    logic [DC_W-1:0]      dead_cycle_count;
    logic [TSIZE_W-1:0]   size_q;
    logic                 pci_tick;
    logic                 take_req;
    logic                 strobe_end;
    logic                 ack_end;
    logic                 cs_idle;

    pci_clk_gen u_pci_clk_gen (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pci_fast_i (pci_fast_i),
        .pci_clk_o  (pci_clk_o),
        .pci_tick_o (pci_tick)
    );

    assign cs_idle  = &cs_n_o;
    assign take_req = (state == ST_IDLE) && pci_tick && req_i;
    // Acknowledge is only looked at once the strobe has run a full period
    assign ack_end    = !ack_n_i;
    assign strobe_end = (state == ST_STROBE) && pci_tick &&
        ((cnt == {1'b0, wait_state_count} + 17'h0_0001) || ack_end);

    // Sequencing; every step waits for a bus clock edge except the trail
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take_req) begin
                        state <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (pci_tick) begin
                        state <= ST_STROBE;
                        cnt   <= '0;
                    end
                end
                ST_STROBE: begin
                    if (strobe_end) begin
                        state <= ST_TRAIL;
                    end else if (pci_tick) begin
                        cnt <= cnt + 17'h0_0001;
                    end
                end
                ST_TRAIL: begin
                    cnt   <= '0;
                    state <= (dead_cycle_count == '0) ? ST_IDLE : ST_DEAD;
                end
                ST_DEAD: begin
                    if (pci_tick) begin
                        if (cnt[DC_W-1:0] == dead_cycle_count - 4'h1) begin
                            state <= ST_IDLE;
                        end else begin
                            cnt <= cnt + 17'h0_0001;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Access parameters are frozen for the whole cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_idx           <= '0;
            addr_q           <= ADDR_RESET;
            mode_q           <= MODE_LEGACY;
            wait_state_count <= '0;
            dead_cycle_count <= '0;
            size_q           <= TSIZE_RESET;
        end else if (take_req) begin
            cs_idx           <= req_cs_i;
            addr_q           <= req_addr_i;
            mode_q           <= mode_i;
            wait_state_count <= wait_state_count_i;
            dead_cycle_count <= dead_cycle_count_i;
            size_q           <= (mode_i == MODE_GRAPHICS) ? req_size_i
                                                          : TSIZE_RESET;
        end
    end

    // Direction, write data and start strobe open the lead period
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rw_o                      <= 1'b1;
            data_o                    <= DATA_RESET;
            data_oe_o                 <= 1'b0;
            transfer_start_strobe_n_o <= 1'b1;
        end else if (take_req) begin
            rw_o                      <= req_read_i;
            data_o                    <= req_wdata_i;
            data_oe_o                 <= !req_read_i;
            transfer_start_strobe_n_o <= !is_wide(mode_i);
        end else if (state == ST_LEAD && pci_tick) begin
            transfer_start_strobe_n_o <= 1'b1;
        end else if (state == ST_TRAIL) begin
            data_oe_o <= 1'b0;
        end
    end

    // Address lands one core clock after the direction, so it leads chip
    // select by less than a bus clock but at least one core clock
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_pend             <= 1'b0;
            addr_o                <= ADDR_RESET;
            addr_hi_oe_o          <= 1'b0;
            transfer_size_field_o <= TSIZE_RESET;
        end else if (take_req) begin
            addr_pend <= 1'b1;
        end else if (state == ST_LEAD && addr_pend) begin
            addr_pend             <= 1'b0;
            addr_o                <= addr_q;
            addr_hi_oe_o          <= is_wide(mode_q);
            transfer_size_field_o <= size_q;
        end else if (strobe_end && is_wide(mode_q)) begin
            addr_hi_oe_o <= 1'b0;
        end else if (state == ST_TRAIL) begin
            addr_hi_oe_o          <= 1'b0;
            transfer_size_field_o <= TSIZE_RESET;
        end
    end

    // Chip select and output enable move together on bus clock edges
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_n_o  <= CS_N_RESET;
            oe_n_o  <= 1'b1;
            rdata_o <= DATA_RESET;
            acked_o <= 1'b0;
        end else if (state == ST_LEAD && pci_tick) begin
            cs_n_o         <= CS_N_RESET;
            cs_n_o[cs_idx] <= 1'b0;
            oe_n_o         <= !rw_o;
        end else if (strobe_end) begin
            cs_n_o  <= CS_N_RESET;
            oe_n_o  <= 1'b1;
            rdata_o <= rw_o ? data_i : rdata_o;
            acked_o <= ack_end;
        end
    end

    // Handshake toward the requester
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            accept_o <= 1'b0;
            done_o   <= 1'b0;
            busy_o   <= 1'b0;
        end else begin
            accept_o <= take_req;
            done_o   <= (state == ST_TRAIL && dead_cycle_count == '0) ||
                        (state == ST_DEAD && pci_tick &&
                         cnt[DC_W-1:0] == dead_cycle_count - 4'h1);
            if (take_req) begin
                busy_o <= 1'b1;
            end else if (done_o) begin
                busy_o <= 1'b0;
            end
        end
    end

    // Checking helpers and properties
    logic [CNT_W-1:0] strobe_ticks;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_ticks <= '0;
        end else if (cs_idle) begin
            strobe_ticks <= '0;
        end else if (pci_tick) begin
            strobe_ticks <= strobe_ticks + 17'h0_0001;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_lead;
        cs_idle ##1 cs_idle;
    endsequence

    sequence s_strobe_start;
        ##[0:6] (!cs_idle && $stable(rw_o));
    endsequence

    AST_ONE_CS: assert property ($onehot0(~cs_n_o))
        else $error("more than one chip select active");

    AST_CS_LEN: assert property (
        ($rose(cs_idle) && !acked_o) |->
            (strobe_ticks == {1'b0, wait_state_count} + 17'h0_0002))
        else $error("chip select width differs from two plus wait states");

    AST_ACK_END: assert property (
        (state == ST_STROBE && pci_tick && !ack_n_i) |=>
            (cs_idle && acked_o))
        else $error("acknowledge did not end the strobe");

    AST_RW_LEAD: assert property (
        $rose(busy_o) |-> s_lead ##0 s_strobe_start)
        else $error("direction not settled a bus clock before select");

    AST_ADDR_SETUP: assert property (
        $fell(cs_idle) |-> ($stable(addr_o) && !addr_pend))
        else $error("address not set up before chip select");

    AST_WDATA_HOLD: assert property (
        ($rose(cs_idle) && !rw_o) |-> (data_oe_o ##1 !data_oe_o))
        else $error("write data not held one core clock");

    AST_RW_HOLD: assert property (
        $rose(cs_idle) |=> ($stable(rw_o) && $stable(addr_o)))
        else $error("direction or address changed right after negation");

    AST_TS_ONLY: assert property (
        (!transfer_start_strobe_n_o) |->
            (is_wide(mode_q) && cs_idle))
        else $error("start strobe outside wide modes or during select");

    AST_TS_END: assert property (
        $rose(transfer_start_strobe_n_o) |-> $fell(cs_idle))
        else $error("start strobe did not end at chip select");

    AST_TSIZE: assert property (
        (mode_q != MODE_GRAPHICS) |-> (transfer_size_field_o == '0))
        else $error("size field driven outside graphics mode");

    AST_HI_RELEASE: assert property (
        ($rose(cs_idle) && is_wide(mode_q)) |-> !addr_hi_oe_o)
        else $error("upper address pins not released with select");

    AST_GAP: assert property (
        $rose(cs_idle) |=> cs_idle[*2])
        else $error("next chip select came too soon");
endmodule : ebus_seq

// *** common/ebus_pkg.sv ***
// Constants and types shared by the external bus sequencer files
package ebus_pkg;
    // Bus geometry
    localparam int CS_COUNT   = 8;
    localparam int CS_IDX_W   = 3;
    localparam int ADDR_W     = 26;
    localparam int ADDR_LO_W  = 16;
    localparam int DATA_W     = 32;
    localparam int WS_W       = 16;
    localparam int DC_W       = 4;
    localparam int TSIZE_W    = 2;
    localparam int DIV_W      = 3;
    localparam int CNT_W      = WS_W + 1;

    // Timing: core clock is the internal peripheral clock
    localparam int CORE_CLK_PERIOD_NS = 100;
    localparam int PCI_FAST_PERIOD_NS = 200;
    localparam int PCI_SLOW_PERIOD_NS = 400;
    localparam int PCI_MAX_MHZ        = 66;
    localparam logic [DIV_W-1:0] PCI_FAST_DIV = DIV_W'(
        (PCI_FAST_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);
    localparam logic [DIV_W-1:0] PCI_SLOW_DIV = DIV_W'(
        (PCI_SLOW_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);

    // Reset values of the pins
    localparam logic [CS_COUNT-1:0] CS_N_RESET   = 8'hff;
    localparam logic [ADDR_W-1:0]   ADDR_RESET   = 26'h000_0000;
    localparam logic [DATA_W-1:0]   DATA_RESET   = 32'h0000_0000;
    localparam logic [TSIZE_W-1:0]  TSIZE_RESET  = 2'h0;

    // Bus modes of the non-multiplexed single access
    typedef enum logic [1:0] {
        MODE_LEGACY,
        MODE_WIDE_FLASH,
        MODE_GRAPHICS
    } bus_mode_t;

    // Modes that use the shared upper address pins and the start strobe
    function automatic logic is_wide(input logic [1:0] mode);
        is_wide = (mode == MODE_WIDE_FLASH) || (mode == MODE_GRAPHICS);
    endfunction : is_wide
endpackage : ebus_pkg

// *** rtl/pci_clk_gen.sv ***
// Divider that sources the bus reference clock from the core clock
module pci_clk_gen
    import ebus_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    // Rate select: 1 for the fast rate
    input  wire logic pci_fast_i,
    // Generated clock and its rising-edge marker
    output logic      pci_clk_o,
    output logic      pci_tick_o
);
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] div_sel;

    // Rate change only at a period boundary so no short pulse goes out
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt    <= '0;
            div_sel    <= PCI_SLOW_DIV;
            pci_clk_o  <= 1'b0;
            pci_tick_o <= 1'b0;
        end else if (div_cnt == div_sel - 3'h1) begin
            div_cnt    <= '0;
            div_sel    <= pci_fast_i ? PCI_FAST_DIV : PCI_SLOW_DIV;
            pci_clk_o  <= 1'b1;
            pci_tick_o <= 1'b1;
        end else begin
            div_cnt    <= div_cnt + 3'h1;
            pci_tick_o <= 1'b0;
            if (div_cnt == (div_sel >> 1) - 3'h1) begin
                pci_clk_o <= 1'b0;
            end
        end
    end

    AST_PCI_RATE: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        pci_tick_o |=> !pci_tick_o)
        else $error("bus clock period shorter than two core cycles");
endmodule : pci_clk_gen

// *** sim/ebus_target.sv ***
// Behavioural external target: answers reads, may acknowledge early
module ebus_target
    import ebus_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    // Bus pins seen from the target
    input  wire logic                pci_clk_i,
    input  wire logic [CS_COUNT-1:0] cs_n_i,
    input  wire logic                oe_n_i,
    output logic                     ack_n_o,
    output logic [DATA_W-1:0]        data_o,
    // Bench control: acknowledge after this many bus periods, 0 never
    input  wire logic [3:0]          ack_after_i,
    input  wire logic [DATA_W-1:0]   rd_word_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic              pci_q;
    logic              sel;
    logic [3:0]        periods;
    logic [DATA_W-1:0] last;
    assign sel = (cs_n_i != CS_N_RESET);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pci_q   <= 1'b0;
            periods <= 4'h0;
        end else begin
            pci_q <= pci_clk_i;
            if (!sel) begin
                periods <= 4'h0;
            end else if (pci_clk_i && !pci_q && periods != 4'hf) begin
                periods <= periods + 4'h1;
            end
        end
    end
    // Never before one bus period; dropped as soon as select goes away
    assign ack_n_o = !(sel && ack_after_i != 4'h0 &&
                       periods >= ack_after_i);
    // No pull-up: a released bus shows the inverse, not a stale match
    assign data_o = (sel && !oe_n_i) ? rd_word_i : ~last;
    always_ff @(posedge core_clk_i) begin
        if (sel && !oe_n_i) begin
            last <= rd_word_i;
        end
    end
endmodule : ebus_target

// *** sim/tb_ebus_seq.sv ***
// Self-checking bench for the external bus cycle sequencer
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_ebus_seq
    import ebus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i, rst_i, pci_fast_i, req_i, req_read_i;
    logic accept_o, done_o, busy_o, acked_o, pci_clk_o, addr_hi_oe_o;
    logic rw_o, oe_n_o, data_oe_o, ack_n_i, transfer_start_strobe_n_o;
    logic [1:0]          mode_i;
    logic [WS_W-1:0]     wait_state_count_i;
    logic [DC_W-1:0]     dead_cycle_count_i;
    logic [CS_IDX_W-1:0] req_cs_i;
    logic [ADDR_W-1:0]   req_addr_i, addr_o;
    logic [DATA_W-1:0]   req_wdata_i, rdata_o, data_o, data_i, rd_word;
    logic [TSIZE_W-1:0]  req_size_i, transfer_size_field_o;
    logic [CS_COUNT-1:0] cs_n_o;
    logic [3:0]          ack_after;
    int                  errors, cmp_count, cycles;

    ebus_seq dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .pci_fast_i(pci_fast_i), .mode_i(mode_i),
        .wait_state_count_i(wait_state_count_i),
        .dead_cycle_count_i(dead_cycle_count_i), .req_i(req_i),
        .req_cs_i(req_cs_i), .req_read_i(req_read_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_size_i(req_size_i), .accept_o(accept_o), .done_o(done_o),
        .busy_o(busy_o), .acked_o(acked_o), .rdata_o(rdata_o),
        .pci_clk_o(pci_clk_o), .cs_n_o(cs_n_o), .addr_o(addr_o),
        .addr_hi_oe_o(addr_hi_oe_o), .rw_o(rw_o), .oe_n_o(oe_n_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i),
        .ack_n_i(ack_n_i),
        .transfer_start_strobe_n_o(transfer_start_strobe_n_o),
        .transfer_size_field_o(transfer_size_field_o));
    ebus_target target (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .pci_clk_i(pci_clk_o), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o),
        .ack_n_o(ack_n_i), .data_o(data_i), .ack_after_i(ack_after),
        .rd_word_i(rd_word));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    task automatic end_sim;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // Inputs change and outputs are read 10 ns after the edge
    task automatic step;
        @(posedge core_clk_i);
        #10;
    endtask : step

    task automatic clk_period(input int div);
        int n;
        n = 0;
        while (pci_clk_o !== 1'b0) step();
        while (pci_clk_o !== 1'b1) step();
        while (pci_clk_o !== 1'b0) begin step(); n++; end
        while (pci_clk_o !== 1'b1) begin step(); n++; end
        `CHK(n, div)
    endtask : clk_period

    task automatic access(input logic [1:0] md, input logic rd,
        input logic [2:0] cs, input int ws, input int dc, input int ak);
        int n, w, m, st, rw_run, div, expw;
        logic wide;
        logic [ADDR_W-1:0] a, pa;
        logic [DATA_W-1:0] d, pd;
        logic [1:0] sz, ps, esz;
        logic pe;
        div = pci_fast_i ? int'(PCI_FAST_DIV) : int'(PCI_SLOW_DIV);
        wide = (md != MODE_LEGACY);
        a = 26'h2a5_5a3c ^ {23'h0, cs};
        d = 32'hc3a5_0f00 | {29'h0, cs};
        sz = cs[1:0];
        esz = (md == MODE_GRAPHICS) ? sz : TSIZE_RESET;
        mode_i = md; req_read_i = rd; req_cs_i = cs; req_addr_i = a;
        req_wdata_i = d; req_size_i = sz; ack_after = ak[3:0];
        wait_state_count_i = ws[WS_W-1:0]; rd_word = ~d;
        dead_cycle_count_i = dc[DC_W-1:0];
        req_i = 1'b1;
        n = 0;
        do begin step(); n++; end while (accept_o !== 1'b1 && n < 50);
        req_i = 1'b0;
        `CHK(accept_o, 1'b1)
        `CHK(busy_o, 1'b1)
        rw_run = 0; st = 0;
        while (cs_n_o === CS_N_RESET && n < 200) begin
            rw_run = (rw_o === rd) ? rw_run + 1 : 0;
            st += (transfer_start_strobe_n_o === 1'b0);
            pa = addr_o; pd = data_o; pe = data_oe_o;
            ps = transfer_size_field_o;
            step(); n++;
        end
        `CHK(cs_n_o, ~(8'h01 << cs))
        `CHK(oe_n_o, !rd)
        `CHK(rw_run >= div, 1'b1)
        `CHK(pa, a)
        `CHK(pe, !rd)
        if (!rd) `CHK(pd, d)
        `CHK(ps, esz)
        `CHK(st, wide ? div : 0)
        `CHK(transfer_start_strobe_n_o, 1'b1)
        `CHK(addr_hi_oe_o, wide)
        w = 0;
        while (cs_n_o !== CS_N_RESET && w < 400) begin step(); w++; end
        expw = (ak != 0 && ak + 1 < 2 + ws) ? ak + 1 : 2 + ws;
        `CHK(w, expw * div)
        `CHK(rw_o, rd)
        `CHK(addr_o[ADDR_LO_W-1:0], a[ADDR_LO_W-1:0])
        `CHK(addr_hi_oe_o, 1'b0)
        `CHK(data_oe_o, !rd)
        `CHK(transfer_size_field_o, esz)
        m = 0;
        while (done_o !== 1'b1 && m < 200) begin step(); m++; end
        // Dead periods run on the bus clock grid from the negation tick
        `CHK(m, (dc == 0) ? 1 : dc * div)
        `CHK(acked_o, expw < 2 + ws)
        if (rd) `CHK(rdata_o, ~d)
        step();
        `CHK(busy_o, 1'b0)
    endtask : access

    // Ceiling well above the hundred and fifty or so cycles the tests need
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        rst_i = 1'b1; pci_fast_i = 1'b0; req_i = 1'b0; mode_i = 2'h0;
        req_read_i = 1'b0; req_cs_i = 3'h0; req_addr_i = ADDR_RESET;
        req_wdata_i = DATA_RESET; req_size_i = TSIZE_RESET;
        wait_state_count_i = 16'h0000; dead_cycle_count_i = 4'h0;
        ack_after = 4'h0; rd_word = DATA_RESET;
        errors = 0; cmp_count = 0; cycles = 0;
        repeat (2) @(posedge core_clk_i);
        #10;
        `CHK(cs_n_o, CS_N_RESET)
        `CHK(transfer_start_strobe_n_o, 1'b1)
        rst_i = 1'b0;
        clk_period(int'(PCI_SLOW_DIV));
        access(MODE_LEGACY, 1'b0, 3'h0, 0, 0, 0);
        access(MODE_LEGACY, 1'b1, 3'h7, 3, 2, 0);
        access(MODE_WIDE_FLASH, 1'b0, 3'h5, 5, 1, 2);
        access(MODE_WIDE_FLASH, 1'b1, 3'h3, 1, 0, 1);
        pci_fast_i = 1'b1;
        repeat (8) step();
        clk_period(int'(PCI_FAST_DIV));
        access(MODE_GRAPHICS, 1'b1, 3'h6, 2, 0, 1);
        access(MODE_GRAPHICS, 1'b0, 3'h1, 0, 3, 0);
        access(MODE_LEGACY, 1'b0, 3'h2, 4, 0, 7);
        end_sim();
    end
endmodule : tb_ebus_seq
